// ==== hdl/event_latch_bank.sv ====
/*
 * Bank of sticky event flags, one per live bit position of the event mask.
 * Assumes set and clear arrive on the same clock as the bank.
 */
`timescale 1ns/1ps
`include "phy_event_defs.svh"

module event_latch_bank
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // event set and read clear
    input  wire phy_event_pkg::event_vec_type set_vec,
    input  wire phy_event_pkg::event_vec_type clr_vec,
    // latched flags
    output      phy_event_pkg::event_vec_type flag_vec
);
    import phy_event_pkg::*;

    localparam event_vec_type LIVE = `EVENT_MASK;  // reserved bits stay 0

    // ------------------------------------------------------------------
    // one flag per live position; reserved positions are tied to zero
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 16; i++)
        begin : g_flag
            if (LIVE[i])
            begin : g_live
                logic flag_ff;  // sticky flag
                // set wins over a read clear in the same cycle
                always_ff @(posedge clk or posedge reset)
                begin
                    if (reset)
                        flag_ff <= 1'b0;
                    else if (set_vec[i])
                        flag_ff <= 1'b1;
                    else if (clr_vec[i])
                        flag_ff <= 1'b0;
                end
                assign flag_vec[i] = flag_ff;
            end
            else
            begin : g_reserved
                // reserved position, never set
                assign flag_vec[i] = 1'b0;
            end
        end
    endgenerate
endmodule : event_latch_bank

// ==== hdl/phy_event_defs.svh ====
/*
 * Offsets, field positions and reset values of the event interrupt block.
 * Assumes it is included by bare name from each design file that needs it.
 */
`ifndef PHY_EVENT_DEFS_SVH
`define PHY_EVENT_DEFS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ENABLE_IDX          6'h12
`define STATUS_IDX          6'h13
`define CONFIG_IDX          6'h14

// ----------------------------------------------------------------------
// event bit positions, shared by status and enable registers
// ----------------------------------------------------------------------
`define BIT_NEG_ERROR       15
`define BIT_SPEED_CHANGE    14
`define BIT_DUPLEX_CHANGE   13
`define BIT_PAGE_RECEIVED   12
`define BIT_NEG_DONE        11
`define BIT_LINK_CHANGE     10
`define BIT_FALSE_CARRIER   8
`define BIT_PAIR_SWAP       6
`define BIT_DOWNSHIFT       5
`define BIT_SLEEP_CHANGE    4
`define BIT_WAKE_PACKET     3
`define BIT_MAC_IF_ERROR    2
`define BIT_POLARITY_CHANGE 1
`define BIT_JABBER          0

// ----------------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------------
`define EVENT_MASK          16'hFD7F
`define EVENT_RESET         16'h0000
`define POLARITY_BIT        13
`define POLARITY_RESET      1'b1

// ----------------------------------------------------------------------
// bus answer codes
// ----------------------------------------------------------------------
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ==== hdl/phy_event_irq.sv ====
/*
 * Event status, interrupt enable and interrupt pin of the transceiver,
 * reached over an AXI4-Lite register slave.
 * Assumes event inputs are one-cycle or level pulses made by core logic
 * on the same clock, so they need no synchroniser.
 */
`timescale 1ns/1ps
`include "phy_event_defs.svh"

module phy_event_irq
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // write address channel
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output      logic        awready,
    // write data channel
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output      logic        wready,
    // write response channel
    output      logic [1:0]  bresp,
    output      logic        bvalid,
    input  wire logic        bready,
    // read address channel
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output      logic        arready,
    // read data channel
    output      logic [31:0] rdata,
    output      logic [1:0]  rresp,
    output      logic        rvalid,
    input  wire logic        rready,
    // events from the transceiver core
    input  wire logic        negotiation_error,
    input  wire logic        link_speed_change,
    input  wire logic        duplex_change,
    input  wire logic        page_received,
    input  wire logic        negotiation_done,
    input  wire logic        link_state_change,
    input  wire logic        false_carrier,
    input  wire logic        pair_swap_change,
    input  wire logic        speed_downshift,
    input  wire logic        sleep_change,
    input  wire logic        wake_packet,
    input  wire logic        mac_if_error,
    input  wire logic        line_polarity_change,
    input  wire logic        jabber,
    // interrupt pin
    output      logic        irq_pin
);
    import phy_event_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    wr_state_type  wr_state_ff;      // write side progress
    rd_state_type  rd_state_ff;      // read side progress
    logic          awready_ff;       // address slot empty
    logic          wready_ff;        // data slot empty
    logic [5:0]    wr_idx_ff;        // held write word index
    logic [31:0]   wdata_ff;         // held write data
    logic [3:0]    wstrb_ff;         // held byte enables
    logic          bvalid_ff;        // write answer pending
    logic [1:0]    bresp_ff;         // write answer code
    logic          arready_ff;       // read address slot empty
    logic          rvalid_ff;        // read answer pending
    logic [1:0]    rresp_ff;         // read answer code
    logic [31:0]   rdata_ff;         // read answer data
    event_vec_type enable_ff;        // interrupt enable register
    logic          active_low_ff;    // interrupt pin polarity
    logic          irq_ff;           // interrupt pin level
    event_vec_type event_vec;        // events of this cycle
    event_vec_type clear_vec;        // flags cleared by a read
    event_vec_type flag_vec;         // latched event flags
    event_vec_type nxt_enable;       // enable after a write
    logic          nxt_active_low;   // polarity after a write
    logic          wr_fire;          // both write halves held
    logic          ar_fire;          // read address taken
    logic [5:0]    rd_idx;           // read word index
    logic          any_pending;      // enabled flag waiting

    localparam event_vec_type LIVE = `EVENT_MASK;

    // ------------------------------------------------------------------
    // event gathering
    // ------------------------------------------------------------------
    // each source lands on its status position; gaps stay zero
    always_comb
    begin
        event_vec = `EVENT_RESET;
        event_vec[`BIT_NEG_ERROR]       = negotiation_error;
        event_vec[`BIT_SPEED_CHANGE]    = link_speed_change;
        event_vec[`BIT_DUPLEX_CHANGE]   = duplex_change;
        event_vec[`BIT_PAGE_RECEIVED]   = page_received;
        event_vec[`BIT_NEG_DONE]        = negotiation_done;
        event_vec[`BIT_LINK_CHANGE]     = link_state_change;
        event_vec[`BIT_FALSE_CARRIER]   = false_carrier;
        event_vec[`BIT_PAIR_SWAP]       = pair_swap_change;
        event_vec[`BIT_DOWNSHIFT]       = speed_downshift;
        event_vec[`BIT_SLEEP_CHANGE]    = sleep_change;
        event_vec[`BIT_WAKE_PACKET]     = wake_packet;
        event_vec[`BIT_MAC_IF_ERROR]    = mac_if_error;
        event_vec[`BIT_POLARITY_CHANGE] = line_polarity_change;
        event_vec[`BIT_JABBER]          = jabber;
    end

    // ------------------------------------------------------------------
    // read clear of the status register
    // ------------------------------------------------------------------
    assign ar_fire = arvalid && arready_ff && (rd_state_ff == RD_IDLE);
    assign rd_idx  = araddr[7:2];

    // only flags that the read returns are cleared, so an event
    // arriving in the read cycle is kept for the next read
    always_comb
    begin
        if (ar_fire && rd_idx == `STATUS_IDX)
            clear_vec = flag_vec;
        else
            clear_vec = `EVENT_RESET;
    end

    event_latch_bank u_flags
    (
        .clk      (clk),
        .reset    (reset),
        .set_vec  (event_vec),
        .clr_vec  (clear_vec),
        .flag_vec (flag_vec)
    );

    // ------------------------------------------------------------------
    // write side of the bus
    // ------------------------------------------------------------------
    // write happens once both halves are held and no answer is pending
    assign wr_fire = !awready_ff && !wready_ff &&
                     (wr_state_ff == WR_COLLECT);

    // write progress
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            wr_state_ff <= WR_COLLECT;
        else
        begin
            case (wr_state_ff)
                WR_COLLECT:
                    if (wr_fire)
                        wr_state_ff <= WR_RESPOND;
                WR_RESPOND:
                    if (bready)
                        wr_state_ff <= WR_COLLECT;
                default:
                    wr_state_ff <= WR_COLLECT;
            endcase
        end
    end

    // address slot: taken once, freed after the answer
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            awready_ff <= 1'b1;
            wr_idx_ff  <= 6'h00;
        end
        else if (awvalid && awready_ff)
        begin
            awready_ff <= 1'b0;
            wr_idx_ff  <= awaddr[7:2];
        end
        else if (bvalid_ff && bready)
            awready_ff <= 1'b1;
    end

    // data slot: taken independently of the address
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wready_ff <= 1'b1;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end
        else if (wvalid && wready_ff)
        begin
            wready_ff <= 1'b0;
            wdata_ff  <= wdata;
            wstrb_ff  <= wstrb;
        end
        else if (bvalid_ff && bready)
            wready_ff <= 1'b1;
    end

    // write answer; unmapped words get a slave error
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            if (wr_idx_ff == `ENABLE_IDX || wr_idx_ff == `STATUS_IDX ||
                wr_idx_ff == `CONFIG_IDX)
                bresp_ff <= `RESP_OKAY;
            else
                bresp_ff <= `RESP_SLVERR;
        end
        else if (bvalid_ff && bready)
            bvalid_ff <= 1'b0;
    end

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    // byte lanes merge into the enable and polarity values
    always_comb
    begin
        nxt_enable     = enable_ff;
        nxt_active_low = active_low_ff;
        if (wstrb_ff[0])
            nxt_enable[7:0]  = wdata_ff[7:0];
        if (wstrb_ff[1])
        begin
            nxt_enable[15:8] = wdata_ff[15:8];
            nxt_active_low   = wdata_ff[`POLARITY_BIT];
        end
        nxt_enable = nxt_enable & LIVE;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            enable_ff <= `EVENT_RESET;
        else if (wr_fire && wr_idx_ff == `ENABLE_IDX)
            enable_ff <= nxt_enable;
    end

    // polarity bit, active low by default
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            active_low_ff <= `POLARITY_RESET;
        else if (wr_fire && wr_idx_ff == `CONFIG_IDX)
            active_low_ff <= nxt_active_low;
    end

    // ------------------------------------------------------------------
    // read side of the bus
    // ------------------------------------------------------------------
    // read progress
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rd_state_ff <= RD_IDLE;
        else
        begin
            case (rd_state_ff)
                RD_IDLE:
                    if (ar_fire)
                        rd_state_ff <= RD_RESPOND;
                RD_RESPOND:
                    if (rready)
                        rd_state_ff <= RD_IDLE;
                default:
                    rd_state_ff <= RD_IDLE;
            endcase
        end
    end

    // read address slot is free only while no answer waits
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            arready_ff <= 1'b1;
        else if (ar_fire)
            arready_ff <= 1'b0;
        else if (rvalid_ff && rready)
            arready_ff <= 1'b1;
    end

    // read answer, sampled in the cycle the address is taken
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= `RESP_OKAY;
            rdata_ff  <= 32'h0000_0000;
        end
        else if (ar_fire)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= `RESP_OKAY;
            case (rd_idx)
                `ENABLE_IDX:
                    rdata_ff <= {16'h0000, enable_ff};
                `STATUS_IDX:
                    rdata_ff <= {16'h0000, flag_vec & LIVE};
                `CONFIG_IDX:
                begin
                    rdata_ff <= 32'h0000_0000;
                    rdata_ff[`POLARITY_BIT] <= active_low_ff;
                end
                default:
                begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= `RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_ff && rready)
            rvalid_ff <= 1'b0;
    end

    // ------------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------------
    // only enabled flags count
    assign any_pending = |(flag_vec & enable_ff);

    // pin follows flags one cycle late; a read that clears the last
    // enabled flag releases it on the second edge after the address is taken
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq_ff <= `POLARITY_RESET;
        else if (active_low_ff)
            irq_ff <= !any_pending;
        else
            irq_ff <= any_pending;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign awready = awready_ff;
    assign wready  = wready_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = arready_ff;
    assign rvalid  = rvalid_ff;
    assign rresp   = rresp_ff;
    assign rdata   = rdata_ff;
    assign irq_pin = irq_ff;
endmodule : phy_event_irq

// ==== hdl/phy_event_pkg.sv ====
/*
 * Types of the event interrupt block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package phy_event_pkg;
    // write side of the register bus
    typedef enum logic {WR_COLLECT, WR_RESPOND} wr_state_type;
    // read side of the register bus
    typedef enum logic {RD_IDLE, RD_RESPOND} rd_state_type;
    // one bit per event position
    typedef logic [15:0] event_vec_type;
endpackage : phy_event_pkg

// ==== verif/mgmt_host_model.sv ====
/*
 * Management host: AXI4-Lite master reaching the block's registers.
 * Assumes it shares the block's clock; lag slows its answers.
 */
`timescale 1ns/1ps

module mgmt_host_model
(
    // clock, pacing and health
    input  wire logic        clk,
    input  wire logic [3:0]  lag,
    output      logic        hang,
    // write channels
    output      logic [7:0]  awaddr,
    output      logic [31:0] wdata,
    output      logic [3:0]  wstrb,
    output      logic        awvalid, wvalid, bready,
    input  wire logic        awready, wready, bvalid,
    input  wire logic [1:0]  bresp,
    // read channels
    output      logic [7:0]  araddr,
    output      logic        arvalid, rready,
    input  wire logic        arready, rvalid,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp
);
    // idle bus from time zero
    initial
    begin
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} = '0;
        {araddr, arvalid, rready, hang} = '0;
    end

    // one write; each half released when its own ready is seen
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        int  n;
        logic aw_p, w_p;
        n = 0;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge clk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid} <= 2'b11;
        while ((aw_p || w_p) && n < 50)
        begin
            @(posedge clk);
            if (aw_p && awready)
            begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready)
            begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
            n++;
        end
        // a slow host holds off bready
        repeat (lag) @(posedge clk);
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid && ++n < 100);
        r = bresp;
        bready <= 1'b0;
        if (n >= 50) hang = 1'b1;
    endtask : write_reg

    // one read, data taken at the rready handshake edge
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready && ++n < 50);
        arvalid <= 1'b0;
        repeat (lag) @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid && ++n < 100);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
        if (n >= 50) hang = 1'b1;
    endtask : read_reg
endmodule : mgmt_host_model

// ==== verif/phy_event_irq_chk.sv ====
/*
 * Port checker for phy_event_irq, bound to every instance.
 * Assumes the bench holds events low while reset is applied.
 */
`timescale 1ns/1ps
`include "phy_event_defs.svh"

module phy_event_irq_chk
(
    // clock, reset and register bus
    input wire logic        clk, reset,
    input wire logic [7:0]  awaddr, araddr,
    input wire logic [31:0] wdata, rdata,
    input wire logic [3:0]  wstrb,
    input wire logic [1:0]  bresp, rresp,
    input wire logic        awvalid, awready, wvalid, wready,
    input wire logic        bvalid, bready, arvalid, arready,
    input wire logic        rvalid, rready,
    // core events and pin
    input wire logic        negotiation_error, link_speed_change,
    input wire logic        duplex_change, page_received,
    input wire logic        negotiation_done, link_state_change,
    input wire logic        false_carrier, pair_swap_change,
    input wire logic        speed_downshift, sleep_change,
    input wire logic        wake_packet, mac_if_error,
    input wire logic        line_polarity_change, jabber, irq_pin
);
    // events placed at their status positions, holes at 9 and 7
    logic [15:0] ev_now;
    assign ev_now = {negotiation_error, link_speed_change, duplex_change,
        page_received, negotiation_done, link_state_change, 1'b0,
        false_carrier, 1'b0, pair_swap_change, speed_downshift,
        sleep_change, wake_packet, mac_if_error, line_polarity_change,
        jabber};

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    b_holds_a: // bus answer stands
        assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");
    r_holds_a: // bus answer stands
        assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped early");
    wr_lat_a: // write answer two edges on
        assert property (awvalid && awready && wvalid && wready
            |=> !bvalid ##1 bvalid)
        else $error("write answer mistimed");
    rd_lat_a: // read answer one edge on
        assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    wr_busy_a: // no new write while answering
        assert property (bvalid |-> !awready && !wready)
        else $error("write ready while answer pending");
    rd_busy_a: // no new read while answering
        assert property (rvalid |-> !arready)
        else $error("read ready while answer pending");
    rsv_zero_a:
        assert property (rvalid |-> rdata[31:16] == 16'h0000
            && !rdata[9] && !rdata[7])
        else $error("reserved read bits set");
    unmapped_a: // refused address
        assert property (arvalid && arready && !(araddr[7:2] inside
            {`ENABLE_IDX, `STATUS_IDX, `CONFIG_IDX})
            |=> rresp == `RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    ev_capture_a:
        assert property (arvalid && arready && araddr[7:2] == `STATUS_IDX
            |=> (rdata[15:0] & $past(ev_now, 2)) == $past(ev_now, 2))
        else $error("event missing from status read");
endmodule : phy_event_irq_chk

bind phy_event_irq phy_event_irq_chk i_phy_event_irq_chk
(
    .clk(clk), .reset(reset), .awaddr(awaddr), .araddr(araddr),
    .wdata(wdata), .rdata(rdata), .wstrb(wstrb), .bresp(bresp),
    .rresp(rresp), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .negotiation_error(negotiation_error),
    .link_speed_change(link_speed_change), .duplex_change(duplex_change),
    .page_received(page_received), .negotiation_done(negotiation_done),
    .link_state_change(link_state_change), .false_carrier(false_carrier),
    .pair_swap_change(pair_swap_change), .sleep_change(sleep_change),
    .speed_downshift(speed_downshift), .wake_packet(wake_packet),
    .mac_if_error(mac_if_error), .jabber(jabber), .irq_pin(irq_pin),
    .line_polarity_change(line_polarity_change)
);

// ==== verif/phy_event_irq_tb.sv ====
/*
 * Self-checking bench for phy_event_irq: the host model drives the
 * register bus, this module drives the core events and judges.
 */
`timescale 1ns/1ps
`include "phy_event_defs.svh"

module phy_event_irq_tb;
    import phy_event_pkg::*;
    // byte address is four times the index
    localparam logic [7:0] EN_A = {`ENABLE_IDX, 2'b00};
    localparam logic [7:0] ST_A = {`STATUS_IDX, 2'b00};
    localparam logic [7:0] CF_A = {`CONFIG_IDX, 2'b00};
    localparam int POS [14] = '{15,14,13,12,11,10,8,6,5,4,3,2,1,0};
    logic          clk = 1'b0, reset = 1'b1;
    logic [7:0]    awaddr, araddr;
    logic [31:0]   wdata, rdata, d;
    logic [3:0]    wstrb, lag;
    logic [1:0]    bresp, rresp, r;
    logic          awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready, irq_pin, hang;
    event_vec_type ev;
    int            errors, num_checks;

    always #5 clk = ~clk;

    phy_event_irq i_phy_event_irq (.clk(clk), .reset(reset),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .negotiation_error(ev[15]), .link_speed_change(ev[14]),
        .duplex_change(ev[13]), .page_received(ev[12]),
        .negotiation_done(ev[11]), .link_state_change(ev[10]),
        .false_carrier(ev[8]), .pair_swap_change(ev[6]),
        .speed_downshift(ev[5]), .sleep_change(ev[4]),
        .wake_packet(ev[3]), .mac_if_error(ev[2]),
        .line_polarity_change(ev[1]), .jabber(ev[0]), .irq_pin(irq_pin));

    mgmt_host_model i_mgmt_host_model (.clk(clk), .lag(lag), .hang(hang),
        .awaddr(awaddr), .wdata(wdata), .wstrb(wstrb), .awvalid(awvalid),
        .wvalid(wvalid), .bready(bready), .awready(awready),
        .wready(wready), .bvalid(bvalid), .bresp(bresp),
        .araddr(araddr), .arvalid(arvalid), .rready(rready),
        .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp));

    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // compare a bus word; a hung host ends the run
    task automatic check_word(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp || hang)
        begin
            errors++;
            $display("Error %0t: word %h, expected %h", $time, got, exp);
        end
        if (hang) stop_test();
    endtask : check_word

    // compare the interrupt pin level
    task automatic check_pin(input logic exp);
        num_checks++;
        if (irq_pin !== exp)
        begin
            errors++;
            $display("Error %0t: pin %b, expected %b", $time, irq_pin, exp);
        end
    endtask : check_pin

    // one-cycle event pulse, then let flag and pin settle
    task automatic pulse(input event_vec_type m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= '0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse

    task automatic rd(input logic [7:0] a);
        i_mgmt_host_model.read_reg(a, d, r);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_mgmt_host_model.write_reg(a, v, r);
    endtask : wr

    task automatic settle;
        @(posedge clk);
        #1;
    endtask : settle

    task automatic t_reset_values;
        rd(EN_A); check_word(d, 32'h0);
        rd(ST_A); check_word(d, 32'h0);
        rd(CF_A); check_word(d, 32'h2000);
        check_pin(1'b1);
    endtask : t_reset_values

    // every event alone with enables off, then all together
    task automatic t_event_flags;
        for (int i = 0; i < 14; i++)
        begin
            pulse(16'h1 << POS[i]);
            check_pin(1'b1);
            rd(ST_A); check_word(d, 32'h1 << POS[i]);
            rd(ST_A); check_word(d, '0);
        end
        pulse(16'hFFFF);
        rd(ST_A); check_word(d, 32'h0000_FD7F);
    endtask : t_event_flags

    // read-only places ignore writes; with all enables set, a negotiation error drives the active-low pin low
    task automatic t_enable_access;
        wr(EN_A, 32'hFFFF_FFFF); check_word(32'(r), `RESP_OKAY);
        rd(EN_A); check_word(d, 32'h0000_FD7F);
        pulse(16'h8000); check_pin(1'b0);
        rd(ST_A); settle(); check_pin(1'b1);
        wr(ST_A, 32'hFFFF); check_word(32'(r), `RESP_OKAY);
        rd(ST_A); check_word(d, 32'h0);
    endtask : t_enable_access

    // gating by enable and both pin polarities, with a slow host
    task automatic t_irq_gating;
        lag = 4'h3;
        wr(EN_A, 32'h1);
        pulse(16'h0002); check_pin(1'b1);
        pulse(16'h0001); check_pin(1'b0);
        rd(ST_A); check_word(d, 32'h3);
        settle(); check_pin(1'b1);
        wr(CF_A, 32'h0); settle(); check_pin(1'b0);
        wr(EN_A, 32'h4); pulse(16'h4); check_pin(1'b1);
        rd(ST_A); settle(); check_pin(1'b0);
        wr(CF_A, 32'h2000);
        lag = 4'h0;
    endtask : t_irq_gating

    // places outside the map are refused
    task automatic t_unmapped;
        rd(8'h00); check_word(d, 32'h0);
        check_word(32'(r), `RESP_SLVERR);
        wr(8'hFC, 32'hFFFF); check_word(32'(r), `RESP_SLVERR);
    endtask : t_unmapped

    initial
    begin
        errors = 0;
        num_checks = 0;
        ev = '0;
        lag = '0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset_values();
        t_event_flags();
        t_enable_access();
        t_irq_gating();
        t_unmapped();
        stop_test();
    end
endmodule : phy_event_irq_tb
